/* rtl/ssw_consts.svh */
// Constants of the supply supervisor and watchdog block.
// Assumes a 200 MHz clock and a 32-bit classic Wishbone register bus.
//
// Contract
// - Power-up reset held one pulse time
// - Reset polarity is a build option
// - Brown-out asserts reset, at least pulse time
// - Constant watchdog input past interval resets
// - Fresh interval after watchdog reset ends
// - Level change or floating input restarts
// - Pulses of 50 ns count as service
// - Backup only below threshold and backup
// - Back to main above threshold
// - Backup mode keeps reset asserted
// - Backup disables power-fail and watchdog
// - Deep discharge enters low-current state
// - Missing backup supply never switches over
// - Power-fail flag low below reference
// - Power-fail independent except backup mode
// - Floating watchdog level distinct from high/low
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH

// Timing, clock rate and figures as printed
`define SSW_CLK_MHZ        200
`define SSW_RST_PULSE_MS   200
`define SSW_WD_INTERVAL_MS 1600
`define SSW_WDI_PULSE_NS   50
`define SSW_RST_CYCLES     (`SSW_RST_PULSE_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_CYCLES      (`SSW_WD_INTERVAL_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WDI_MIN_CYCLES ((`SSW_WDI_PULSE_NS * `SSW_CLK_MHZ + 999) / 1000)

// Register byte offsets
`define SSW_ADR_CTRL     8'h00
`define SSW_ADR_STATUS   8'h04
`define SSW_ADR_IRQ_STAT 8'h08
`define SSW_ADR_IRQ_MASK 8'h0C

// Control fields and reset value
`define SSW_CTRL_WD_EN   0
`define SSW_CTRL_RST     32'h0000_0001

// Status fields
`define SSW_ST_BELOW_RT  0
`define SSW_ST_BACKUP    1
`define SSW_ST_LOW_PWR   2
`define SSW_ST_PF_LOW    3
`define SSW_ST_RST_ACT   4
`define SSW_ST_WDI_FLOAT 5

// Interrupt event bits
`define SSW_EV_WD_TMO    0
`define SSW_EV_BROWNOUT  1
`define SSW_EV_BACKUP    2
`define SSW_EV_PF_FALL   3
`define SSW_EV_W         4
`define SSW_IRQ_MASK_RST 4'h0

`endif

/* rtl/ssw_pkg.sv */
// Types of the supply supervisor and watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
package ssw_pkg;
  // Reset generator states
  typedef enum logic [1:0] {
    SSW_HOLD,
    SSW_PULSE,
    SSW_RUN
  } ssw_rst_state_t;
endpackage

/* rtl/ssw_supervisor.sv */
// Supply supervisor: reset generator, watchdog, backup switch, power-fail flag.
// Assumes comparator flags from analog logic and a classic Wishbone master.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"

module ssw_supervisor #(
  parameter int unsigned RST_CYCLES  = `SSW_RST_CYCLES,
  parameter int unsigned WD_CYCLES   = `SSW_WD_CYCLES,
  parameter bit          RST_ACT_HIGH = 1'b0
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Asynchronous comparator flags
  input  wire logic        i_vcc_below_rt,
  input  wire logic        i_vcc_below_batt,
  input  wire logic        i_vcc_deep_below_batt,
  input  wire logic        i_pf_sense_below_ref,
  // Watchdog service input, two comparators; both low means floating
  input  wire logic        i_wdi_high,
  input  wire logic        i_wdi_low,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat_r,
  output logic             o_wb_ack_r,
  // Supervisor outputs
  output logic             o_reset_r,
  output logic             o_power_fail_flag_r,
  output logic             o_backup_path_sel_r,
  output logic             o_main_path_sel_r,
  output logic             o_low_power_r,
  output logic             o_irq_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (RST_CYCLES < 2 || WD_CYCLES < 2) begin : g_bad_count
    $error("ssw_supervisor: counts must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, value taken when stages 2 and 3 agree
  localparam int NIN = 6;
  localparam logic [NIN-1:0] SYNC_RST = 6'h01;  // Below threshold at reset

  logic [NIN-1:0] in_raw;
  logic [NIN-1:0] s1_r, s2_r, s3_r, clean_r;

  assign in_raw = {i_wdi_low, i_wdi_high, i_pf_sense_below_ref,
                   i_vcc_deep_below_batt, i_vcc_below_batt, i_vcc_below_rt};

  // Agreement filter
  function automatic logic [NIN-1:0] agree(input logic [NIN-1:0] a,
                                           input logic [NIN-1:0] b,
                                           input logic [NIN-1:0] old);
    agree = (a & b) | (old & (a | b));
  endfunction

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r    <= SYNC_RST;
      s2_r    <= SYNC_RST;
      s3_r    <= SYNC_RST;
      clean_r <= SYNC_RST;
    end else begin
      s1_r    <= in_raw;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      clean_r <= agree(s2_r, s3_r, clean_r);
    end
  end

  logic below_rt, below_batt, deep, pf_low, wdi_hi, wdi_lo;
  assign {wdi_lo, wdi_hi, pf_low, deep, below_batt, below_rt} = clean_r;

  ////////////////////////////////////////////////////////////////////////////
  // Supply mode decode
  logic backup_c, low_power_c, wdi_float_c;
  // A floating backup input keeps its comparator low, so no switchover
  assign backup_c    = below_rt & below_batt;
  assign low_power_c = backup_c & deep;
  assign wdi_float_c = ~(wdi_hi ^ wdi_lo);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and their state
  logic [31:0] ctrl_r;
  logic [`SSW_EV_W-1:0] irq_stat_r, irq_mask_r, ev_c;
  logic wd_en;
  assign wd_en = ctrl_r[`SSW_CTRL_WD_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog service detection
  logic last_hi_r, wd_service_c, wd_timeout_c;
  logic [31:0] wd_cnt_r;
  ssw_pkg::ssw_rst_state_t st_r, st_nxt;
  logic [31:0] rst_cnt_r;

  // Track last valid level; floating leaves it alone
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_hi_r <= 1'b0;
    end else if (!wdi_float_c) begin
      last_hi_r <= wdi_hi;
    end
  end

  assign wd_service_c = wdi_float_c | (wdi_hi != last_hi_r);
  assign wd_timeout_c = (st_r == ssw_pkg::SSW_RUN) && wd_en && !backup_c &&
                        !wd_service_c && (wd_cnt_r == WD_CYCLES - 1);

  // Interval counter, cleared outside normal run
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wd_cnt_r <= 32'h0000_0000;
    end else if (st_r != ssw_pkg::SSW_RUN || !wd_en || backup_c) begin
      wd_cnt_r <= 32'h0000_0000;
    end else if (wd_service_c || wd_timeout_c) begin
      wd_cnt_r <= 32'h0000_0000;
    end else begin
      wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset generator
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ssw_pkg::SSW_HOLD: begin
        if (!below_rt) begin
          st_nxt = ssw_pkg::SSW_PULSE;
        end
      end
      ssw_pkg::SSW_PULSE: begin
        if (below_rt) begin
          st_nxt = ssw_pkg::SSW_HOLD;
        end else if (rst_cnt_r == RST_CYCLES - 1) begin
          st_nxt = ssw_pkg::SSW_RUN;
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (below_rt) begin
          st_nxt = ssw_pkg::SSW_HOLD;
        end else if (wd_timeout_c) begin
          st_nxt = ssw_pkg::SSW_PULSE;
        end
      end
      default: st_nxt = ssw_pkg::SSW_HOLD;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ssw_pkg::SSW_HOLD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pulse width counter
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_cnt_r <= 32'h0000_0000;
    end else if (st_nxt != ssw_pkg::SSW_PULSE || st_r != ssw_pkg::SSW_PULSE) begin
      rst_cnt_r <= 32'h0000_0000;
    end else begin
      rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor outputs
  logic rst_act_c;
  assign rst_act_c = (st_nxt != ssw_pkg::SSW_RUN);

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reset_r           <= RST_ACT_HIGH;
      o_power_fail_flag_r <= 1'b0;
      o_backup_path_sel_r <= 1'b0;
      o_main_path_sel_r   <= 1'b1;
      o_low_power_r       <= 1'b0;
    end else begin
      o_reset_r           <= rst_act_c ? RST_ACT_HIGH : !RST_ACT_HIGH;
      o_power_fail_flag_r <= !backup_c && !pf_low;
      o_backup_path_sel_r <= backup_c;
      o_main_path_sel_r   <= !backup_c;
      o_low_power_r       <= low_power_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection
  logic below_rt_d_r, backup_d_r, pf_flag_d_r;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      below_rt_d_r <= 1'b1;
      backup_d_r   <= 1'b0;
      pf_flag_d_r  <= 1'b0;
    end else begin
      below_rt_d_r <= below_rt;
      backup_d_r   <= backup_c;
      pf_flag_d_r  <= !backup_c && !pf_low;
    end
  end

  always_comb begin
    ev_c = '0;
    ev_c[`SSW_EV_WD_TMO]   = wd_timeout_c;
    ev_c[`SSW_EV_BROWNOUT] = below_rt && !below_rt_d_r;
    ev_c[`SSW_EV_BACKUP]   = backup_c && !backup_d_r;
    ev_c[`SSW_EV_PF_FALL]  = pf_flag_d_r && !backup_c && pf_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, dropped the next
  logic wb_req_c, wb_wr_c;
  assign wb_req_c = i_wb_cyc && i_wb_stb && !o_wb_ack_r;
  assign wb_wr_c  = wb_req_c && i_wb_we;

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [31:0] w_c;
  assign w_c = merge(32'h0000_0000, i_wb_dat, i_wb_sel);

  // Mask write value, merged over the present mask in full width
  logic [31:0] mask_w_c;
  assign mask_w_c = merge({28'h000_0000, irq_mask_r}, i_wb_dat, i_wb_sel);

  // Control and mask registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r     <= `SSW_CTRL_RST;
      irq_mask_r <= `SSW_IRQ_MASK_RST;
    end else if (wb_wr_c) begin
      if (i_wb_adr == `SSW_ADR_CTRL) begin
        ctrl_r <= merge(ctrl_r, i_wb_dat, i_wb_sel) & 32'h0000_0001;
      end
      if (i_wb_adr == `SSW_ADR_IRQ_MASK) begin
        irq_mask_r <= mask_w_c[`SSW_EV_W-1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_r <= '0;
    end else if (wb_wr_c && i_wb_adr == `SSW_ADR_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~w_c[`SSW_EV_W-1:0]) | ev_c;
    end else begin
      irq_stat_r <= irq_stat_r | ev_c;
    end
  end

  // Read data and ack; unmapped reads return zero
  logic [31:0] rd_c;
  always_comb begin
    case (i_wb_adr)
      `SSW_ADR_CTRL:     rd_c = ctrl_r;
      `SSW_ADR_STATUS:   rd_c = {26'h000_0000, wdi_float_c,
                                 st_r != ssw_pkg::SSW_RUN, pf_low,
                                 low_power_c, backup_c, below_rt};
      `SSW_ADR_IRQ_STAT: rd_c = {28'h000_0000, irq_stat_r};
      `SSW_ADR_IRQ_MASK: rd_c = {28'h000_0000, irq_mask_r};
      default:           rd_c = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack_r <= 1'b0;
      o_wb_dat_r <= 32'h0000_0000;
    end else begin
      o_wb_ack_r <= wb_req_c;
      o_wb_dat_r <= (wb_req_c && !i_wb_we) ? rd_c : 32'h0000_0000;
    end
  end

  // Level interrupt
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq_r <= 1'b0;
    end else begin
      o_irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack_r;
  endsequence
  sequence s_ack_once;
    o_wb_ack_r ##1 !o_wb_ack_r;
  endsequence

  a_pulse_end_run: assert property ((st_r == ssw_pkg::SSW_PULSE && !below_rt &&
      rst_cnt_r == RST_CYCLES - 1) |=> st_r == ssw_pkg::SSW_RUN)
    else $error("pulse did not end at count");
  a_pulse_count_up: assert property ((st_r == ssw_pkg::SSW_PULSE && !below_rt &&
      rst_cnt_r != RST_CYCLES - 1) |=> rst_cnt_r == $past(rst_cnt_r) + 1)
    else $error("pulse counter stalled");
  a_brownout_hold: assert property (below_rt |=> st_r == ssw_pkg::SSW_HOLD &&
      o_reset_r == RST_ACT_HIGH)
    else $error("reset not asserted below threshold");
  a_wd_timeout_pulse: assert property ((wd_timeout_c && !below_rt) |=>
      st_r == ssw_pkg::SSW_PULSE ##1 o_reset_r == RST_ACT_HIGH)
    else $error("watchdog timeout gave no pulse");
  a_wd_service_clear: assert property (wd_service_c |=> wd_cnt_r == 0)
    else $error("service did not restart interval");
  a_backup_outputs: assert property (backup_c |=> o_backup_path_sel_r &&
      !o_main_path_sel_r && !o_power_fail_flag_r && wd_cnt_r == 0)
    else $error("backup mode outputs wrong");
  a_main_return: assert property (!below_rt |=> o_main_path_sel_r &&
      !o_backup_path_sel_r)
    else $error("supply not returned to main");
  a_backup_reset: assert property (o_backup_path_sel_r |->
      o_reset_r == RST_ACT_HIGH)
    else $error("reset released in backup mode");
  a_pf_flag_level: assert property ((!backup_c && pf_low) |=>
      !o_power_fail_flag_r)
    else $error("power-fail flag high below reference");
  a_wb_ack_once: assert property (s_req |=> s_ack_once)
    else $error("bus ack not a single cycle");

  // Deep discharge shows on the low-power output
  a_low_power_out: assert property (low_power_c |=> o_low_power_r)
    else $error("low-power output not raised");

  // Power-fail flag high when sense is above reference in main mode
  a_pf_flag_high: assert property ((!backup_c && !pf_low) |=>
      o_power_fail_flag_r)
    else $error("power-fail flag low above reference");

  // Watchdog can never time out in backup mode
  a_wd_off_backup: assert property (backup_c |-> !wd_timeout_c)
    else $error("watchdog timed out in backup mode");

  // Interval starts afresh when a pulse ends
  a_wd_fresh_start: assert property ((st_r == ssw_pkg::SSW_PULSE &&
      st_nxt == ssw_pkg::SSW_RUN) |=> wd_cnt_r == 0)
    else $error("interval not restarted after pulse");

  // Clean level follows stages 2 and 3 once they agree
  a_sync_agree: assert property ((s2_r == s3_r) |=>
      clean_r == $past(s2_r))
    else $error("synchroniser did not take agreed value");

  // New events always land in the sticky status
  a_stat_set_wins: assert property (ev_c != '0 |=>
      (irq_stat_r & $past(ev_c)) == $past(ev_c))
    else $error("event lost in sticky status");

  // Interrupt line follows unmasked status one edge later
  a_irq_level: assert property (o_irq_r == $past(|(irq_stat_r & irq_mask_r)))
    else $error("interrupt line wrong");

endmodule // ssw_supervisor
`default_nettype wire

/* verif/ssw_host_model.sv */
// Host model on the watchdog side: drives the two watchdog level flags.
// Assumes the bench picks a mode; modes change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model (
  // Clock and mode: 0 toggle, 1 held high, 2 floating, 3 short pulses
  input  wire logic       i_clock,
  input  wire logic [1:0] i_mode,
  // Watchdog level flags
  output logic            o_wdi_high,
  output logic            o_wdi_low
);
  logic [4:0] cnt_r = 5'h00;
  logic       lvl_r = 1'b0;
  ////////////////////////////////////////////////////////////////////
  // Service pace: change level every 20 clocks, well inside the interval
  always_ff @(posedge i_clock) begin
    cnt_r <= (cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
    if (cnt_r == 5'h13) lvl_r <= ~lvl_r;
  end
  // Pin levels for each mode
  always_comb begin
    case (i_mode)
      2'h0: {o_wdi_high, o_wdi_low} = {lvl_r, ~lvl_r};
      2'h1: {o_wdi_high, o_wdi_low} = 2'b10;
      2'h2: {o_wdi_high, o_wdi_low} = 2'b00;
      default: {o_wdi_high, o_wdi_low} = {cnt_r < 5'h0A, cnt_r >= 5'h0A};
    endcase
  end
endmodule // ssw_host_model
`default_nettype wire

/* verif/supply_supervisor_watchdog_tb.sv */
// Self-checking bench of the supply supervisor and watchdog.
// Assumes short counts set here and the host model on the watchdog flags.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
  localparam int RC = 20;
  localparam int WC = 50;
  logic        i_clock, i_rst_b, b_rt, b_bat, b_deep, b_pf, wdh, wdl;
  logic        cyc, stb, we, ack, rst, pff, bks, mns, lpw, irq, rsti;
  logic [1:0]  mode;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, q;
  int          mismatches, comparisons, c;
  ////////////////////////////////////////////////////////////////////
  // Design and host model
  ssw_supervisor #(.RST_CYCLES(RC), .WD_CYCLES(WC)) u_dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_vcc_below_rt(b_rt),
    .i_vcc_below_batt(b_bat), .i_vcc_deep_below_batt(b_deep),
    .i_pf_sense_below_ref(b_pf), .i_wdi_high(wdh), .i_wdi_low(wdl),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat_r(rdat), .o_wb_ack_r(ack),
    .o_reset_r(rst), .o_power_fail_flag_r(pff), .o_backup_path_sel_r(bks),
    .o_main_path_sel_r(mns), .o_low_power_r(lpw), .o_irq_r(irq));
  // Inverted-polarity build on the same inputs
  ssw_supervisor #(.RST_CYCLES(RC), .WD_CYCLES(WC), .RST_ACT_HIGH(1'b1)) u_dut_inv (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_vcc_below_rt(b_rt),
    .i_vcc_below_batt(b_bat), .i_vcc_deep_below_batt(b_deep),
    .i_pf_sense_below_ref(b_pf), .i_wdi_high(wdh), .i_wdi_low(wdl),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat_r(), .o_wb_ack_r(),
    .o_reset_r(rsti), .o_power_fail_flag_r(), .o_backup_path_sel_r(),
    .o_main_path_sel_r(), .o_low_power_r(), .o_irq_r());
  ssw_host_model u_host (.i_clock(i_clock), .i_mode(mode),
    .o_wdi_high(wdh), .o_wdi_low(wdl));
  ////////////////////////////////////////////////////////////////////
  // Verdict and shared checks
  task finish_test;
    $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task inrng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return rst;
      1: return pff;
      2: return bks;
      3: return mns;
      default: return lpw;
    endcase
  endfunction
  // Bounded wait for an output level, edges counted in c
  task wfor(input int s, input logic v, input int n);
    c = 0;
    while (pick(s) !== v) begin
      @(posedge i_clock);
      c++;
      if (c > n) begin
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        finish_test;
      end
    end
  endtask
  task hold(input int s, input logic v, input int n);
    repeat (n) begin
      @(posedge i_clock);
      chk(pick(s), v);
      chk(rsti, !rst);
    end
  endtask
  // Classic Wishbone single cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    @(posedge i_clock);
    while (ack !== 1'b1) begin
      @(posedge i_clock);
      n++;
      if (n > 20) begin
        mismatches++;
        $display("BAD %0t no bus answer", $time);
        finish_test;
      end
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_power;
    chk({rst, mns, bks}, 3'b010);
    chk(rsti, 1'b1);
    @(posedge i_clock);
    b_rt <= 1'b0;
    wfor(0, 1'b1, RC + 20);
    inrng(c, RC, RC + 8);
  endtask
  task t_regs;
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'h1);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b0, 8'h10, 32'h0); chk(q, 32'h0);
    wb(1'b1, 8'h08, 32'hF);
    wb(1'b1, 8'h0C, 32'hF);
    wb(1'b0, 8'h0C, 32'h0); chk(q, 32'hF);
  endtask
  task t_wdog;
    mode <= 2'h1;
    wfor(0, 1'b0, WC + 30); inrng(c, WC - 25, WC + 8);
    wfor(0, 1'b1, RC + 10); inrng(c, RC - 2, RC + 6);
    wfor(0, 1'b0, WC + 10); inrng(c, WC - 2, WC + 6);
    mode <= 2'h0;
    wfor(0, 1'b1, RC + 10);
    wb(1'b0, 8'h08, 32'h0); chk(q[0], 1'b1);
    chk(irq, 1'b1);
    wb(1'b1, 8'h0C, 32'h0); repeat (3) @(posedge i_clock); chk(irq, 1'b0);
    wb(1'b1, 8'h0C, 32'hF); wb(1'b1, 8'h08, 32'hF);
    repeat (3) @(posedge i_clock); chk(irq, 1'b0);
    wb(1'b1, 8'h00, 32'h0); mode <= 2'h1; hold(0, 1'b1, 2 * WC);
    mode <= 2'h0; wb(1'b1, 8'h00, 32'h1);
  endtask
  task t_service;
    for (int m = 0; m < 4; m++) begin
      if (m != 1) begin
        mode <= 2'(m);
        hold(0, 1'b1, 3 * WC);
      end
    end
    mode <= 2'h0;
  endtask
  task t_pf;
    b_pf <= 1'b1;
    wfor(1, 1'b0, 8);
    hold(0, 1'b1, 5);
    wb(1'b0, 8'h04, 32'h0); chk(q[3], 1'b1);
    b_pf <= 1'b0;
    wfor(1, 1'b1, 8);
    wb(1'b0, 8'h08, 32'h0); chk(q[3], 1'b1);
  endtask
  task t_brown;
    b_rt <= 1'b1;
    wfor(0, 1'b0, 8);
    hold(2, 1'b0, 10); chk(mns, 1'b1);
    b_bat <= 1'b1;
    wfor(2, 1'b1, 8); chk({mns, pff, rst}, 3'b000);
    b_deep <= 1'b1;
    wfor(4, 1'b1, 8);
    mode <= 2'h1; hold(0, 1'b0, WC + 10);
    b_deep <= 1'b0; b_rt <= 1'b0;
    wfor(3, 1'b1, 8); chk(bks, 1'b0);
    wfor(0, 1'b1, RC + 10); inrng(c, RC, RC + 8);
    mode <= 2'h0;
    wb(1'b0, 8'h08, 32'h0); chk(q[2:1], 2'b11);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  initial begin
    {i_rst_b, b_rt, b_bat, b_deep, b_pf, cyc, stb, we} = 8'b01000000;
    {mode, adr, dat, mismatches, comparisons} = '0;
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_power;
    t_regs;
    t_wdog;
    t_service;
    t_pf;
    t_brown;
    finish_test;
  end
endmodule // supply_supervisor_watchdog_tb
`default_nettype wire
